// >>> dsr_pkg.sv
package dsr_pkg;

   // Sample and bus widths
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned ADDR_W   = 10;
   localparam int unsigned DATA_W   = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_OUT_ROUTE  = 8'h2A;
   localparam logic [7:0] IDX_PLAY_ROUTE = 8'h2E;
   localparam logic [7:0] IDX_POLARITY   = 8'h99;
   localparam logic [7:0] IDX_STATUS     = 8'h9A;
   localparam logic [1:0] BYTE_LANE_PAD  = 2'h0;

   // Field positions
   localparam int unsigned SRC_R_LSB  = 4;
   localparam int unsigned SRC_L_LSB  = 0;
   localparam int unsigned MONO_R_BIT = 7;
   localparam int unsigned MONO_L_BIT = 3;
   localparam int unsigned INV_R_BIT  = 7;
   localparam int unsigned INV_L_BIT  = 3;
   localparam int unsigned STS_OUT_BIT  = 0;
   localparam int unsigned STS_SKID_BIT = 1;

   // Reset values and writable-bit masks (reserved bits read as zero)
   localparam logic [7:0] OUT_ROUTE_RST   = 8'h10;
   localparam logic [7:0] PLAY_ROUTE_RST  = 8'h32;
   localparam logic [7:0] POLARITY_RST    = 8'h00;
   localparam logic [7:0] OUT_ROUTE_MASK  = 8'h33;
   localparam logic [7:0] PLAY_ROUTE_MASK = 8'hBB;
   localparam logic [7:0] POLARITY_MASK   = 8'h88;

   // Source selector encoding
   typedef enum logic [1:0] {
      DSR_SRC_ADC_L  = 2'h0,
      DSR_SRC_TONE   = 2'h1,
      DSR_SRC_PORT_L = 2'h2,
      DSR_SRC_PORT_R = 2'h3
   } dsr_src_t;

   typedef logic signed [SAMPLE_W-1:0] dsr_sample_t;

   typedef struct packed {
      dsr_sample_t left;
      dsr_sample_t right;
   } dsr_pair_t;

   // One sample period of every source
   typedef struct packed {
      dsr_sample_t adc_l;
      dsr_sample_t tone;
      dsr_sample_t port_l;
      dsr_sample_t port_r;
   } dsr_in_t;

   // One sample period of every routed destination
   typedef struct packed {
      dsr_pair_t port_out;
      dsr_pair_t play;
   } dsr_out_t;

endpackage

// >>> dsr_router.sv
`timescale 1ns/1ps
// Summary of operation
// - Port right output source from bits 5:4 of output routing; resets to tone (0x1).
// - Port left output source from bits 1:0, same encoding; resets to ADC left (0x0).
// - Right mono bit 7 replaces port right input with left/right mono mix.
// - Left mono bit 3 replaces port left input with left/right mono mix.
// - Right playback source from bits 5:4 of playback routing; resets to 0x3.
// - Left playback source from bits 1:0, same encoding; resets to port left (0x2).
// - Inversion bits negate right/left playback input stream; both reset to zero.
module dsr_router (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic [dsr_pkg::ADDR_W-1:0]    avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [dsr_pkg::DATA_W-1:0]    avs_writedata_i,
   input  wire logic [3:0]                    avs_byteenable_i,
   output logic      [dsr_pkg::DATA_W-1:0]    avs_readdata_o,
   output logic                               avs_waitrequest_o,
   input  wire logic                          in_valid_i,
   input  wire dsr_pkg::dsr_in_t              in_data_i,
   output logic                               in_ready_o,
   output logic                               out_valid_o,
   output dsr_pkg::dsr_out_t                  out_data_o,
   input  wire logic                          out_ready_i
);

   localparam int unsigned W = dsr_pkg::SAMPLE_W;

   logic [7:0]            out_route;
   logic [7:0]            play_route;
   logic [7:0]            polarity;
   logic [7:0]            reg_index;
   logic                  addr_ok;
   logic [7:0]            rd_byte;
   logic                  wr_take;
   logic                  skid_valid;
   dsr_pkg::dsr_out_t     skid_data;
   dsr_pkg::dsr_out_t     next_frame;
   dsr_pkg::dsr_sample_t  port_l_eff;
   dsr_pkg::dsr_sample_t  port_r_eff;
   dsr_pkg::dsr_sample_t  play_l_raw;
   dsr_pkg::dsr_sample_t  play_r_raw;
   logic                  accept;
   logic                  next_out_valid;
   logic                  next_skid_valid;
   logic                  load_out_from_skid;
   logic                  load_out_from_in;
   logic                  load_skid;

   // Halved sum of two samples; one extra bit keeps the sum from wrapping
   function automatic dsr_pkg::dsr_sample_t mono_mix(input dsr_pkg::dsr_sample_t a,
                                                    input dsr_pkg::dsr_sample_t b);
      logic signed [W:0] sum;
      sum = {a[W-1], a} + {b[W-1], b};
      return sum[W:1];
   endfunction

   // Negation saturates at full scale, since the most negative code has no positive twin
   function automatic dsr_pkg::dsr_sample_t negate(input dsr_pkg::dsr_sample_t x);
      dsr_pkg::dsr_sample_t most_neg;
      most_neg = {1'b1, {(W-1){1'b0}}};
      if (x == most_neg) begin
         return ~most_neg;
      end
      return -x;
   endfunction

   // Four-way source selector shared by all destinations
   function automatic dsr_pkg::dsr_sample_t pick(input logic [1:0] sel,
                                                input dsr_pkg::dsr_sample_t adc_l,
                                                input dsr_pkg::dsr_sample_t tone,
                                                input dsr_pkg::dsr_sample_t pl,
                                                input dsr_pkg::dsr_sample_t pr);
      case (dsr_pkg::dsr_src_t'(sel))
         dsr_pkg::DSR_SRC_ADC_L:  return adc_l;
         dsr_pkg::DSR_SRC_TONE:   return tone;
         dsr_pkg::DSR_SRC_PORT_L: return pl;
         default:                 return pr;
      endcase
   endfunction

   // Address decode: only whole-word addresses of the mapped indices answer with data
   assign reg_index = avs_address_i[dsr_pkg::ADDR_W-1:2];
   assign addr_ok   = (avs_address_i[1:0] == dsr_pkg::BYTE_LANE_PAD);
   assign wr_take   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0] & addr_ok;

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      rd_byte = 8'h00;
      if (addr_ok) begin
         case (reg_index)
            dsr_pkg::IDX_OUT_ROUTE:  rd_byte = out_route;
            dsr_pkg::IDX_PLAY_ROUTE: rd_byte = play_route;
            dsr_pkg::IDX_POLARITY:   rd_byte = polarity;
            dsr_pkg::IDX_STATUS: begin
               rd_byte[dsr_pkg::STS_OUT_BIT]  = out_valid_o;
               rd_byte[dsr_pkg::STS_SKID_BIT] = skid_valid;
            end
            default:                 rd_byte = 8'h00;
         endcase
      end
   end

   // Bus handshake: every access is held one cycle, then answered for exactly one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= '0;
      end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o    <= {{(dsr_pkg::DATA_W-8){1'b0}}, rd_byte};
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // Output routing register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_route <= dsr_pkg::OUT_ROUTE_RST;
      end else if (wr_take && reg_index == dsr_pkg::IDX_OUT_ROUTE) begin
         out_route <= avs_writedata_i[7:0] & dsr_pkg::OUT_ROUTE_MASK;
      end
   end

   // Playback routing and mono-mix register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         play_route <= dsr_pkg::PLAY_ROUTE_RST;
      end else if (wr_take && reg_index == dsr_pkg::IDX_PLAY_ROUTE) begin
         play_route <= avs_writedata_i[7:0] & dsr_pkg::PLAY_ROUTE_MASK;
      end
   end

   // Playback polarity register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         polarity <= dsr_pkg::POLARITY_RST;
      end else if (wr_take && reg_index == dsr_pkg::IDX_POLARITY) begin
         polarity <= avs_writedata_i[7:0] & dsr_pkg::POLARITY_MASK;
      end
   end

   // Routing datapath; the whole frame is formed from one register snapshot,
   // so a selector change can only land between two samples
   always_comb begin
      port_l_eff = in_data_i.port_l;
      port_r_eff = in_data_i.port_r;
      if (play_route[dsr_pkg::MONO_L_BIT]) begin
         port_l_eff = mono_mix(in_data_i.port_l, in_data_i.port_r);
      end
      if (play_route[dsr_pkg::MONO_R_BIT]) begin
         port_r_eff = mono_mix(in_data_i.port_l, in_data_i.port_r);
      end
      next_frame.port_out.right = pick(out_route[dsr_pkg::SRC_R_LSB +: 2],
         in_data_i.adc_l, in_data_i.tone, port_l_eff, port_r_eff);
      next_frame.port_out.left  = pick(out_route[dsr_pkg::SRC_L_LSB +: 2],
         in_data_i.adc_l, in_data_i.tone, port_l_eff, port_r_eff);
      play_r_raw = pick(play_route[dsr_pkg::SRC_R_LSB +: 2],
         in_data_i.adc_l, in_data_i.tone, port_l_eff, port_r_eff);
      play_l_raw = pick(play_route[dsr_pkg::SRC_L_LSB +: 2],
         in_data_i.adc_l, in_data_i.tone, port_l_eff, port_r_eff);
      next_frame.play.right = polarity[dsr_pkg::INV_R_BIT] ? negate(play_r_raw)
                                                           : play_r_raw;
      next_frame.play.left  = polarity[dsr_pkg::INV_L_BIT] ? negate(play_l_raw)
                                                           : play_l_raw;
   end

   // Two-entry buffer control: output stage plus one skid entry
   assign accept = in_valid_i & in_ready_o;

   always_comb begin
      load_out_from_skid = 1'b0;
      load_out_from_in   = 1'b0;
      load_skid          = 1'b0;
      next_out_valid     = out_valid_o;
      next_skid_valid    = skid_valid;
      if (out_ready_i | ~out_valid_o) begin
         if (skid_valid) begin
            load_out_from_skid = 1'b1;
            next_out_valid     = 1'b1;
            next_skid_valid    = 1'b0;
         end else begin
            load_out_from_in = accept;
            next_out_valid   = accept;
         end
      end else if (accept) begin
         load_skid       = 1'b1;
         next_skid_valid = 1'b1;
      end
   end

   // Buffer state; ready is registered so a stall reaches the source a cycle late,
   // which the skid entry absorbs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         skid_valid  <= 1'b0;
         in_ready_o  <= 1'b0;
      end else begin
         out_valid_o <= next_out_valid;
         skid_valid  <= next_skid_valid;
         in_ready_o  <= ~next_skid_valid;
      end
   end

   // Buffer data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_data_o <= '0;
         skid_data  <= '0;
      end else begin
         if (load_out_from_skid) begin
            out_data_o <= skid_data;
         end else if (load_out_from_in) begin
            out_data_o <= next_frame;
         end
         if (load_skid) begin
            skid_data <= next_frame;
         end
      end
   end

endmodule

// >>> dsr_router_checker.sv
`timescale 1ns/1ps
// Bus and stream handshake checks, bound to the router's ports
module dsr_router_checker (
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic [dsr_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic                       avs_read_i,
   input wire logic                       avs_write_i,
   input wire logic [dsr_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic                       avs_waitrequest_o,
   input wire logic                       in_valid_i,
   input wire logic                       in_ready_o,
   input wire logic                       out_valid_o,
   input wire dsr_pkg::dsr_out_t          out_data_o,
   input wire logic                       out_ready_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request still waiting, then a one-cycle answer
   sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
   sequence s_ans; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
   property p_ans; s_req |=> s_ans; endproperty
   a_ans: assert property (p_ans) else $error("bus answer late or long");
   property p_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_hi; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_mis;
      avs_read_i && avs_waitrequest_o && avs_address_i[1:0] != 2'h0 |=> avs_readdata_o == 32'h0;
   endproperty
   a_mis: assert property (p_mis) else $error("misaligned read not zero");
   property p_take; in_valid_i && in_ready_o |=> out_valid_o; endproperty
   a_take: assert property (p_take) else $error("taken frame not offered");
   property p_hold;
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("frame changed while stalled");
   property p_drop; $fell(in_ready_o) |-> $past(out_valid_o && !out_ready_i); endproperty
   a_drop: assert property (p_drop) else $error("ready dropped without stall");
   property p_back; !in_ready_o && out_ready_i |=> in_ready_o; endproperty
   a_back: assert property (p_back) else $error("ready not restored");
endmodule

bind dsr_router dsr_router_checker u_chk (.*);

// >>> dsr_sink.sv
`timescale 1ns/1ps
// Playback and port sink; mode 0 prompt, 1 slow, 2 stalled
module dsr_sink (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [1:0]        mode_i,
   input  wire logic              valid_i,
   input  wire dsr_pkg::dsr_out_t data_i,
   output logic                   ready_o,
   output dsr_pkg::dsr_out_t      last_o,
   output logic [7:0]             count_o
);
   // Slow mode alternates ready so the skid path gets exercised
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
         count_o <= 8'h00;
      end else begin
         ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && !ready_o);
         if (valid_i && ready_o) begin
            last_o  <= data_i;
            count_o <= count_o + 8'h01;
         end
      end
   end
endmodule

// >>> dsr_router_tb.sv
`timescale 1ns/1ps
module dsr_router_tb;
   typedef struct packed {logic [7:0] o, p, v; logic [31:0] e;} dsr_row_t;
   logic              clk_i = 0, rst_i = 1, rd = 0, wr = 0, iv = 0, wt, ir, ov, ordy;
   logic [9:0]        adr = 10'h0;
   logic [31:0]       wd = 32'h0, rdat, res;
   logic [1:0]        mode = 2'h0;
   logic [3:0]        be = 4'hF;
   logic [7:0]        cnt;
   dsr_pkg::dsr_in_t  din = 96'h0;
   dsr_pkg::dsr_out_t dout, last;
   int                n_errors = 0, checked = 0, i, k, j0;
   // Expected outputs, one byte per sample, sign-extended when compared
   dsr_row_t rows [6] = '{'{8'h10, 8'h32, 8'h00, 32'h01020408},
      '{8'h32, 8'h01, 8'h00, 32'h04080201}, '{8'h23, 8'h10, 8'h88, 32'h0804FFFE},
      '{8'h32, 8'hAB, 8'h00, 32'h06060606}, '{8'h32, 8'hB2, 8'h08, 32'h0406FC06},
      '{8'h01, 8'h3A, 8'h80, 32'h020106F8}};
   dsr_router DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .in_valid_i(iv), .in_data_i(din),
      .in_ready_o(ir), .out_valid_o(ov), .out_data_o(dout), .out_ready_i(ordy));
   dsr_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .valid_i(ov),
      .data_i(dout), .ready_o(ordy), .last_o(last), .count_o(cnt));
   // Clock
   always #5 clk_i = !clk_i;
   function automatic dsr_pkg::dsr_out_t sx(input logic [31:0] e);
      return {{16{e[31]}}, e[31:24], {16{e[23]}}, e[23:16],
              {16{e[15]}}, e[15:8], {16{e[7]}}, e[7:0]};
   endfunction
   task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Hold the request until waitrequest is sampled low, take data there
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] ln = 2'h0);
      @(posedge clk_i);
      adr <= {idx, ln};
      wd <= {24'h0, d};
      rd <= !w;
      wr <= w;
      do @(posedge clk_i); while (wt !== 1'b0);
      res = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic send(input dsr_pkg::dsr_in_t f);
      @(posedge clk_i);
      din <= f;
      iv <= 1'b1;
      do @(posedge clk_i); while (ir !== 1'b1);
      iv <= 1'b0;
   endtask
   task automatic summarize;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog sized well past the whole sequence
   initial begin
      repeat (4000) @(posedge clk_i);
      n_errors++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 8'h2A, 8'h00);
      chk("out_route", res, 8'h10);
      bus(0, 8'h2E, 8'h00);
      chk("play_route", res, 8'h32);
      bus(0, 8'h99, 8'h00);
      chk("polarity", res, 8'h00);
      $display("reset values done");
      for (i = 0; i < 6; i++) begin
         bus(1, 8'h2A, rows[i].o);
         bus(1, 8'h2E, rows[i].p);
         bus(1, 8'h99, rows[i].v);
         k = cnt;
         send({24'h1, 24'h2, 24'h4, 24'h8});
         for (j0 = 0; j0 < 20 && cnt == k; j0++) @(posedge clk_i);
         chk("frame", last, sx(rows[i].e));
         $display("row %0d done", i);
      end
      // Reserved bits, unmapped and misaligned places, then a write with its lane off
      bus(1, 8'h99, 8'hFF);
      bus(0, 8'h99, 8'h00);
      chk("pol_rb", res, 8'h88);
      bus(0, 8'h2B, 8'h00);
      chk("unmapped", res, 0);
      bus(0, 8'h2A, 8'h00, 2'h1);
      chk("misaligned", res, 0);
      bus(1, 8'h99, 8'h80);
      be <= 4'h0;
      bus(1, 8'h99, 8'h08);
      be <= 4'hF;
      bus(0, 8'h99, 8'h00);
      chk("lane_off", res, 8'h80);
      $display("register test done");
      // Stalled sink: two frames fit, then ready drops; drain slowly in order
      mode <= 2'h2;
      din <= {24'h1, 24'h10, 24'h4, 24'h8};
      iv <= 1'b1;
      k = 0;
      repeat (8) begin
         @(posedge clk_i);
         if (ir === 1'b1 && iv === 1'b1) begin
            k++;
            din.tone <= 24'h10 + k;
         end
      end
      iv <= 1'b0;
      chk("takes", k, 2);
      chk("in_ready", ir, 1'b0);
      // Status shows both buffer entries full while the sink still stalls
      bus(0, 8'h9A, 8'h00);
      chk("status", res, 8'h03);
      j0 = cnt;
      mode <= 2'h1;
      repeat (12) @(posedge clk_i);
      chk("drained", cnt - j0[7:0], 8'h02);
      chk("order", last.port_out.left, 24'h11);
      $display("buffer test done");
      // Reset in mid-run; held four edges so the drop of ready lies inside the reset span
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("ov_rst", ov, 1'b0);
      chk("ir_rst", ir, 1'b0);
      chk("dout_rst", dout, 96'h0);
      rst_i <= 1'b0;
      bus(0, 8'h2A, 8'h00);
      chk("out_route_rst", res, 8'h10);
      bus(0, 8'h2E, 8'h00);
      chk("play_route_rst", res, 8'h32);
      bus(0, 8'h99, 8'h00);
      chk("polarity_rst", res, 8'h00);
      chk("ir_back", ir, 1'b1);
      $display("reset test done");
      summarize();
   end
endmodule
